//--- bench/pus_far_model.sv
// Far side of the sequencer: supply monitors and both oscillators.
// Assumes the bench drives supply state just after a rising clock edge.
`timescale 1ns/100ps
module pus_far_model #(
    parameter int RC_DIV = 4,
    parameter int OSC_DIV = 2,
    parameter int POR_LEN = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_supply_up,
    input wire logic i_supply_sag,
    input wire logic i_osc_stop,
    output logic o_por_pulse,
    output logic o_brown_out,
    output logic o_rc_tick,
    output logic o_osc_tick
);
    logic [7:0] rc_q = 8'h00;
    logic [7:0] osc_q = 8'h00;
    logic [7:0] por_q = 8'h00;
    always @(posedge i_sys_clk) begin
        rc_q <= (rc_q == 8'(RC_DIV - 1)) ? 8'h00 : rc_q + 8'h01;
        if (i_osc_stop) begin
            osc_q <= 8'h00;
        end else begin
            osc_q <= (osc_q == 8'(OSC_DIV - 1)) ? 8'h00 : osc_q + 8'h01;
        end
        if (!i_supply_up) begin
            por_q <= 8'h00;
        end else if (por_q != 8'(POR_LEN)) begin
            por_q <= por_q + 8'h01;
        end
    end
    assign o_rc_tick = (rc_q == 8'(RC_DIV - 1));
    assign o_osc_tick = !i_osc_stop && (osc_q == 8'(OSC_DIV - 1));
    assign o_por_pulse = !i_supply_up || (por_q != 8'(POR_LEN));
    assign o_brown_out = i_supply_sag;
endmodule

//--- bench/pus_sequencer_chk.sv
// Assertion checker of the power-up reset sequencer, bound to its ports.
// Assumes one clock and the register map of the package.
`timescale 1ns/100ps
module pus_sequencer_chk
    import pus_pkg::*;
#(
    parameter int POWER_UP_TIMER_TICKS = PUS_POWER_UP_TIMER_TICKS,
    parameter int PLL_TICKS = PUS_PLL_TICKS
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_por_pulse,
    input wire logic i_brown_out_detect,
    input wire logic i_master_clear_pin_n,
    input wire logic i_rc_tick,
    input wire logic i_oscillator_in_pin_tick,
    input wire logic i_sleep_exec,
    input wire logic i_wdt_reset,
    input wire logic i_irq_wake,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    input wire logic o_wb_ack,
    input wire logic o_core_reset,
    input wire logic o_osc_stop,
    input wire logic o_hold_first_quarter_phase,
    input wire logic o_osc_out_port_a_bits_6,
    input wire logic o_osc_out_drive_low,
    input wire logic o_feedback_inv_disable
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    logic [4:0] cfg_q;
    logic [15:0] slow_q;
    logic [15:0] xtal_q;
    logic [11:0] low_q;
    logic pwron_q;
    logic sag;
    logic [2:0] md;
    assign md = cfg_q[PUS_CFG_MODE_LSB +: PUS_CFG_MODE_W];
    assign sag = cfg_q[PUS_CFG_BOR_EN_BIT] && i_brown_out_detect;
    // Shadow of the config register and stage counters
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            cfg_q <= PUS_CFG_RESET;
        end else if (i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && i_wb_sel[0]
                     && i_wb_adr == PUS_ADDR_CONFIG) begin
            cfg_q <= i_wb_dat[4:0];
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || i_por_pulse || sag) begin
            slow_q <= 16'h0000;
        end else if (i_rc_tick && slow_q != 16'hFFFF) begin
            slow_q <= slow_q + 16'h0001;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || i_por_pulse) begin
            xtal_q <= 16'h0000;
        end else if (i_oscillator_in_pin_tick && xtal_q != 16'hFFFF) begin
            xtal_q <= xtal_q + 16'h0001;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || i_por_pulse || i_master_clear_pin_n) begin
            low_q <= 12'h000;
        end else if (low_q != 12'hFFF) begin
            low_q <= low_q + 12'h001;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || i_por_pulse) begin
            pwron_q <= 1'b1;
        end else if (sag || !o_core_reset) begin
            pwron_q <= 1'b0;
        end
    end
    sequence s_late_release;
        pwron_q && low_q >= 12'd2500 ##1 i_master_clear_pin_n;
    endsequence
    sequence s_sleep_cmd;
        i_sleep_exec && !o_core_reset && !o_osc_stop && i_master_clear_pin_n
            && !i_por_pulse && !sag;
    endsequence
    a_por_hold: assert property (i_por_pulse [*4] |-> o_core_reset)
        else $error("core not held during power-on pulse");
    a_sag_hold: assert property (sag [*4] |-> o_core_reset)
        else $error("core not held during brown-out");
    a_timer_min: assert property ($fell(o_core_reset) && cfg_q[PUS_CFG_POWER_UP_TIMER_EN_BIT]
        |-> slow_q >= POWER_UP_TIMER_TICKS)
        else $error("reset released before power-up delay");
    a_xtal_min: assert property ($fell(o_core_reset) && pwron_q && md <= PUS_MODE_HIGH_SPEED_PLL_MODE
        |-> xtal_q >= 16'd1024)
        else $error("reset released before start-up count");
    a_no_delay: assert property ($fell(i_por_pulse) && md == PUS_MODE_RC
        && !cfg_q[PUS_CFG_POWER_UP_TIMER_EN_BIT] && i_master_clear_pin_n
        |-> ##[1:8] !o_core_reset)
        else $error("time-out applied with no stage enabled");
    a_late_run: assert property (s_late_release |=> !o_core_reset)
        else $error("late pin release did not start execution");
    a_pin_hold: assert property (!i_master_clear_pin_n |=> o_core_reset)
        else $error("reset released while pin low");
    a_sleep_entry: assert property (s_sleep_cmd |=> o_osc_stop
        && o_hold_first_quarter_phase)
        else $error("sleep did not stop oscillator");
    a_sleep_wake: assert property (o_osc_stop && (i_wdt_reset || i_irq_wake) |=> !o_osc_stop)
        else $error("no wake from sleep");
    a_sleep_pins: assert property ({o_osc_out_port_a_bits_6, o_osc_out_drive_low,
        o_feedback_inv_disable} == (o_osc_stop ? {md == PUS_MODE_EXTERNAL_CLOCK_IO_MODE, md == PUS_MODE_EC,
        md == PUS_MODE_HS || md == PUS_MODE_HIGH_SPEED_PLL_MODE} : 3'h0))
        else $error("wrong oscillator pin state");
    a_wb_ack: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
        else $error("bus acknowledge not a single pulse");
endmodule
bind pus_sequencer pus_sequencer_chk #(.POWER_UP_TIMER_TICKS(POWER_UP_TIMER_TICKS), .PLL_TICKS(PLL_TICKS)) chk_u (
    .i_sys_clk, .i_rst, .i_por_pulse, .i_brown_out_detect, .i_master_clear_pin_n, .i_rc_tick,
    .i_oscillator_in_pin_tick, .i_sleep_exec, .i_wdt_reset, .i_irq_wake, .i_wb_cyc, .i_wb_stb,
    .i_wb_we, .i_wb_adr, .i_wb_dat, .i_wb_sel, .o_wb_ack, .o_core_reset, .o_osc_stop,
    .o_hold_first_quarter_phase, .o_osc_out_port_a_bits_6, .o_osc_out_drive_low,
    .o_feedback_inv_disable);

//--- bench/tb_power_up_reset_sequencer.sv
// Self-checking bench of the power-up reset sequencer.
// Assumes the far-side model and the bound checker.
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %0t: got %0h expected %0h", $time, (g), (e)); end end
module tb_power_up_reset_sequencer;
    import pus_pkg::*;
    localparam int SLOW_LIM = 10;
    localparam int LOCK_LIM = 4;
    localparam int RC_DIV = 4;
    localparam int OSC_DIV = 2;
    localparam int POR_LEN = 8;
    typedef struct packed {
        logic [2:0] md; logic pw; logic [2:0] pins; logic [1:0] wake;
    } pus_row_t;
    pus_row_t rows [8] = '{'{PUS_MODE_LP, 1'b1, 3'h0, 2'd0}, '{PUS_MODE_XT, 1'b1, 3'h0, 2'd1},
        '{PUS_MODE_HS, 1'b1, 3'h1, 2'd2}, '{PUS_MODE_HIGH_SPEED_PLL_MODE, 1'b1, 3'h1, 2'd1},
        '{PUS_MODE_EC, 1'b1, 3'h2, 2'd2}, '{PUS_MODE_EXTERNAL_CLOCK_IO_MODE, 1'b1, 3'h4, 2'd1},
        '{PUS_MODE_RC, 1'b1, 3'h0, 2'd2}, '{PUS_MODE_RC, 1'b0, 3'h0, 2'd1}};
    logic i_sys_clk, i_rst = 1'b1, i_master_clear_pin_n = 1'b1, i_sleep_exec = 1'b0;
    logic i_wdt_reset = 1'b0, i_irq_wake = 1'b0, i_wb_cyc = 1'b0, i_wb_stb = 1'b0;
    logic i_wb_we = 1'b0, supply_up = 1'b0, supply_sag = 1'b0, hit;
    logic [7:0] i_wb_adr = 8'h00;
    logic [31:0] i_wb_dat = 32'h0, q;
    logic [3:0] i_wb_sel = 4'h0;
    logic i_por_pulse, i_brown_out_detect, i_rc_tick, i_oscillator_in_pin_tick;
    logic o_wb_ack, o_core_reset, o_osc_stop, o_hold_first_quarter_phase;
    logic o_osc_out_port_a_bits_6, o_osc_out_drive_low, o_feedback_inv_disable;
    logic [31:0] o_wb_dat;
    int fails = 0, samples_checked = 0, n, ex;
    pus_sequencer #(.POWER_UP_TIMER_TICKS(SLOW_LIM), .PLL_TICKS(LOCK_LIM)) dut_u (
        .i_sys_clk, .i_rst, .i_por_pulse, .i_brown_out_detect, .i_master_clear_pin_n,
        .i_rc_tick, .i_oscillator_in_pin_tick, .i_sleep_exec, .i_wdt_reset, .i_irq_wake,
        .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat, .i_wb_sel, .o_wb_ack, .o_wb_dat,
        .o_core_reset, .o_osc_stop, .o_hold_first_quarter_phase, .o_osc_out_port_a_bits_6,
        .o_osc_out_drive_low, .o_feedback_inv_disable);
    pus_far_model #(.RC_DIV(RC_DIV), .OSC_DIV(OSC_DIV), .POR_LEN(POR_LEN)) far_u (
        .i_sys_clk, .i_supply_up(supply_up), .i_supply_sag(supply_sag), .i_osc_stop(o_osc_stop),
        .o_por_pulse(i_por_pulse), .o_brown_out(i_brown_out_detect), .o_rc_tick(i_rc_tick),
        .o_osc_tick(i_oscillator_in_pin_tick));
    initial begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end
    // ------------------------------------------------------------------
    // Bus, supply and closing tasks
    // ------------------------------------------------------------------
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r);
        int k;
        @(posedge i_sys_clk);
        {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat, i_wb_sel} <= {2'b11, w, a, d, s};
        k = 0;
        do begin
            @(posedge i_sys_clk);
            k++;
        end while (o_wb_ack !== 1'b1 && k < 20);
        r = o_wb_dat;
        {i_wb_cyc, i_wb_stb, i_wb_we} <= 3'b000;
        `CHK(k < 20, 1'b1)
    endtask
    task automatic up_start(input logic [2:0] m, input logic pw, input logic be);
        @(posedge i_sys_clk) supply_up <= 1'b0;
        wb(1'b1, PUS_ADDR_CONFIG, {27'h0, m, be, pw}, 4'h1, q);
        @(posedge i_sys_clk) supply_up <= 1'b1;
    endtask
    task automatic wait_run(output int c);
        c = 0;
        while (o_core_reset !== 1'b0 && c < 5000) begin
            @(posedge i_sys_clk);
            c++;
        end
    endtask
    task end_sim;
        $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge i_sys_clk);
        fails++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        wb(1'b0, PUS_ADDR_CONFIG, 32'h0, 4'hF, q);
        `CHK(q, {27'h0, PUS_CFG_RESET})
        wb(1'b0, PUS_ADDR_STATUS, 32'h0, 4'hF, q);
        `CHK(q[PUS_ST_RESET_BIT], 1'b1)
        wb(1'b1, 8'h08, 32'hFF, 4'hF, q);
        wb(1'b1, PUS_ADDR_CONFIG, 32'h18, 4'h0, q);
        wb(1'b0, 8'h08, 32'h0, 4'hF, q);
        `CHK(q, 32'h0)
        wb(1'b0, PUS_ADDR_CONFIG, 32'h0, 4'hF, q);
        `CHK(q[4:0], PUS_CFG_RESET)
        foreach (rows[i]) begin
            up_start(rows[i].md, rows[i].pw, 1'b1);
            wait_run(n);
            ex = POR_LEN + (rows[i].pw ? SLOW_LIM * RC_DIV : 0);
            ex += (rows[i].md <= PUS_MODE_HIGH_SPEED_PLL_MODE) ? 1024 * OSC_DIV : 0;
            ex += (rows[i].md == PUS_MODE_HIGH_SPEED_PLL_MODE) ? LOCK_LIM * RC_DIV : 0;
            `CHK(n >= ex - 4 && n <= ex + 20, 1'b1)
            @(posedge i_sys_clk) i_sleep_exec <= 1'b1;
            @(posedge i_sys_clk) i_sleep_exec <= 1'b0;
            repeat (2) @(posedge i_sys_clk);
            `CHK({o_osc_stop, o_hold_first_quarter_phase}, 2'b11)
            `CHK({o_osc_out_port_a_bits_6, o_osc_out_drive_low, o_feedback_inv_disable},
                 rows[i].pins)
            @(posedge i_sys_clk);
            {i_master_clear_pin_n, i_wdt_reset, i_irq_wake} <= {rows[i].wake != 2'd0,
                rows[i].wake == 2'd1, rows[i].wake == 2'd2};
            repeat (4) @(posedge i_sys_clk);
            {i_master_clear_pin_n, i_wdt_reset, i_irq_wake} <= 3'b100;
            repeat (2200) @(posedge i_sys_clk);
            `CHK({o_osc_stop, o_core_reset}, 2'b00)
        end
        up_start(PUS_MODE_RC, 1'b1, 1'b1);
        repeat (POR_LEN + 23) @(posedge i_sys_clk);
        supply_sag <= 1'b1;
        repeat (10) @(posedge i_sys_clk);
        `CHK(o_core_reset, 1'b1)
        supply_sag <= 1'b0;
        wait_run(n);
        `CHK(n >= SLOW_LIM * RC_DIV - 4 && n <= SLOW_LIM * RC_DIV + 12, 1'b1)
        wb(1'b1, PUS_ADDR_CONFIG, {27'h0, PUS_MODE_RC, 2'b01}, 4'h1, q);
        @(posedge i_sys_clk) supply_sag <= 1'b1;
        hit = 1'b0;
        repeat (12) begin
            @(posedge i_sys_clk);
            hit |= o_core_reset;
        end
        supply_sag <= 1'b0;
        `CHK(hit, 1'b0)
        @(posedge i_sys_clk) i_master_clear_pin_n <= 1'b0;
        up_start(PUS_MODE_XT, 1'b1, 1'b1);
        repeat (2700) @(posedge i_sys_clk);
        `CHK(o_core_reset, 1'b1)
        i_master_clear_pin_n <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        `CHK(o_core_reset, 1'b0)
        // Mid-run reset: outputs return to their reset values
        i_rst <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        `CHK({o_core_reset, o_osc_stop, o_wb_ack}, 3'h4)
        i_rst <= 1'b0;
        wb(1'b0, PUS_ADDR_CONFIG, 32'h0, 4'hF, q);
        `CHK(q, {27'h0, PUS_CFG_RESET})
        wait_run(n);
        ex = 3 + SLOW_LIM * RC_DIV + 1024 * OSC_DIV;
        `CHK(n >= ex - 4 && n <= ex + 20, 1'b1)
        end_sim();
    end
endmodule

//--- pkg/pus_pkg.sv
// Constants, register map and state type of the power-up reset sequencer.
// Assumes a 125 MHz system clock and a classic Wishbone register bus.
package pus_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] PUS_ADDR_CONFIG = 8'h00;
    localparam logic [7:0] PUS_ADDR_STATUS = 8'h04;

    // Config fields
    localparam int PUS_CFG_POWER_UP_TIMER_EN_BIT = 0;
    localparam int PUS_CFG_BOR_EN_BIT = 1;
    localparam int PUS_CFG_MODE_LSB = 2;
    localparam int PUS_CFG_MODE_W = 3;
    localparam logic [4:0] PUS_CFG_RESET = 5'h03;

    // Status fields
    localparam int PUS_ST_STATE_LSB = 0;
    localparam int PUS_ST_POR_FLAG_BIT = 4;
    localparam int PUS_ST_BOR_FLAG_BIT = 5;
    localparam int PUS_ST_RESET_BIT = 6;
    localparam int PUS_ST_SLEEP_BIT = 7;

    // ------------------------------------------------------------------
    // Oscillator mode encodings
    // ------------------------------------------------------------------
    localparam logic [2:0] PUS_MODE_LP = 3'h0;
    localparam logic [2:0] PUS_MODE_XT = 3'h1;
    localparam logic [2:0] PUS_MODE_HS = 3'h2;
    localparam logic [2:0] PUS_MODE_HIGH_SPEED_PLL_MODE = 3'h3;
    localparam logic [2:0] PUS_MODE_EC = 3'h4;
    localparam logic [2:0] PUS_MODE_EXTERNAL_CLOCK_IO_MODE = 3'h5;
    localparam logic [2:0] PUS_MODE_RC = 3'h6;

    // ------------------------------------------------------------------
    // Timing, in ticks of each stage's source clock
    // ------------------------------------------------------------------
    localparam int PUS_TMR_W = 22;
    localparam int PUS_RC_OSC_KHZ = 250;
    localparam int PUS_POWER_UP_TIMER_TIME_MS = 72;
    localparam int PUS_PLL_TIME_MS = 2;
    localparam int PUS_POWER_UP_TIMER_TICKS = PUS_POWER_UP_TIMER_TIME_MS * PUS_RC_OSC_KHZ;
    localparam int PUS_PLL_TICKS = PUS_PLL_TIME_MS * PUS_RC_OSC_KHZ;
    localparam int PUS_OST_CYCLES = 1024;

    typedef enum logic [2:0] {
        PUS_ST_POR,
        PUS_ST_BOR,
        PUS_ST_POWER_UP_TIMER,
        PUS_ST_OST,
        PUS_ST_PLL,
        PUS_ST_RUN,
        PUS_ST_SLEEP
    } pus_state_t;

endpackage

//--- pkg/pus_tmr_if.sv
// Link between the sequencer and its shared stage timer.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface pus_tmr_if;
    import pus_pkg::*;
    logic clr;
    logic tick;
    logic [PUS_TMR_W-1:0] limit;
    logic done;
    modport ctrl (output clr, output tick, output limit, input done);
    modport tmr (input clr, input tick, input limit, output done);
endinterface

//--- src/pus_sequencer.sv
// Power-up reset sequencer with Wishbone register access.
// Assumes synchronous i_rst, 125 MHz clock, tick pulses from the RC and
// crystal oscillators, and asynchronous supply-monitor inputs.
`timescale 1ns/100ps
module pus_sequencer
    import pus_pkg::*;
#(
    parameter int POWER_UP_TIMER_TICKS = PUS_POWER_UP_TIMER_TICKS,
    parameter int PLL_TICKS = PUS_PLL_TICKS
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_por_pulse,
    input wire logic i_brown_out_detect,
    input wire logic i_master_clear_pin_n,
    input wire logic i_rc_tick,
    input wire logic i_oscillator_in_pin_tick,
    input wire logic i_sleep_exec,
    input wire logic i_wdt_reset,
    input wire logic i_irq_wake,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic o_wb_ack,
    output logic [31:0] o_wb_dat,
    output logic o_core_reset,
    output logic o_osc_stop,
    output logic o_hold_first_quarter_phase,
    output logic o_osc_out_port_a_bits_6,
    output logic o_osc_out_drive_low,
    output logic o_feedback_inv_disable
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic is_crystal(input logic [2:0] mode);
        is_crystal = (mode == PUS_MODE_LP) || (mode == PUS_MODE_XT) ||
                     (mode == PUS_MODE_HS) || (mode == PUS_MODE_HIGH_SPEED_PLL_MODE);
    endfunction

    // Stage that follows the power-up timer, or replaces it when skipped
    function automatic pus_state_t after_power_up_timer(input logic por_cause,
                                              input logic [2:0] mode);
        if (por_cause && is_crystal(mode)) begin
            after_power_up_timer = PUS_ST_OST;
        end else begin
            after_power_up_timer = PUS_ST_RUN;
        end
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    pus_state_t state_q;
    pus_state_t state_d;
    logic por_meta_q;
    logic por_sync_q;
    logic bor_meta_q;
    logic bor_sync_q;
    logic por_cause_q;
    logic [4:0] cfg_q;
    logic por_flag_q;
    logic bor_flag_q;
    logic wb_req;
    logic wb_wr;
    logic power_up_timer_en;
    logic bor_en;
    logic [2:0] osc_mode;
    logic sleep_next;
    logic [31:0] status_word;

    pus_tmr_if tmr_link ();

    assign power_up_timer_en = cfg_q[PUS_CFG_POWER_UP_TIMER_EN_BIT];
    assign bor_en = cfg_q[PUS_CFG_BOR_EN_BIT];
    assign osc_mode = cfg_q[PUS_CFG_MODE_LSB +: PUS_CFG_MODE_W];

    // ------------------------------------------------------------------
    // Supply monitor synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            por_meta_q <= 1'b1;
            por_sync_q <= 1'b1;
        end else begin
            por_meta_q <= i_por_pulse;
            por_sync_q <= por_meta_q;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            bor_meta_q <= 1'b0;
            bor_sync_q <= 1'b0;
        end else begin
            bor_meta_q <= i_brown_out_detect;
            bor_sync_q <= bor_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Sequence state
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        if (por_sync_q) begin
            state_d = PUS_ST_POR;
        end else if (bor_en && bor_sync_q) begin
            state_d = PUS_ST_BOR;
        end else begin
            case (state_q)
                PUS_ST_POR, PUS_ST_BOR: begin
                    if (power_up_timer_en) begin
                        state_d = PUS_ST_POWER_UP_TIMER;
                    end else begin
                        state_d = after_power_up_timer(state_q == PUS_ST_POR, osc_mode);
                    end
                end
                PUS_ST_POWER_UP_TIMER: begin
                    if (tmr_link.done) begin
                        state_d = after_power_up_timer(por_cause_q, osc_mode);
                    end
                end
                PUS_ST_OST: begin
                    if (tmr_link.done) begin
                        if (por_cause_q && osc_mode == PUS_MODE_HIGH_SPEED_PLL_MODE) begin
                            state_d = PUS_ST_PLL;
                        end else begin
                            state_d = PUS_ST_RUN;
                        end
                    end
                end
                PUS_ST_PLL: begin
                    if (tmr_link.done) begin
                        state_d = PUS_ST_RUN;
                    end
                end
                PUS_ST_RUN: begin
                    if (i_sleep_exec && i_master_clear_pin_n) begin
                        state_d = PUS_ST_SLEEP;
                    end
                end
                PUS_ST_SLEEP: begin
                    if (!i_master_clear_pin_n || i_wdt_reset || i_irq_wake) begin
                        if (is_crystal(osc_mode)) begin
                            state_d = PUS_ST_OST;
                        end else begin
                            state_d = PUS_ST_RUN;
                        end
                    end
                end
                default: begin
                    state_d = PUS_ST_POR;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state_q <= PUS_ST_POR;
        end else begin
            state_q <= state_d;
        end
    end

    // Cause of the running sequence; decides on start-up and lock stages
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            por_cause_q <= 1'b1;
        end else if (state_d == PUS_ST_POR) begin
            por_cause_q <= 1'b1;
        end else if (state_d == PUS_ST_BOR || state_d == PUS_ST_SLEEP) begin
            por_cause_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Shared stage timer
    // ------------------------------------------------------------------
    // Restart on every stage change, so a repeated brown-out reloads it
    assign tmr_link.clr = (state_d != state_q);

    always_comb begin
        tmr_link.tick = 1'b0;
        tmr_link.limit = '0;
        case (state_q)
            PUS_ST_POWER_UP_TIMER: begin
                tmr_link.tick = i_rc_tick;
                tmr_link.limit = POWER_UP_TIMER_TICKS[PUS_TMR_W-1:0];
            end
            PUS_ST_OST: begin
                tmr_link.tick = i_oscillator_in_pin_tick;
                tmr_link.limit = PUS_TMR_W'(PUS_OST_CYCLES);
            end
            PUS_ST_PLL: begin
                tmr_link.tick = i_rc_tick;
                tmr_link.limit = PLL_TICKS[PUS_TMR_W-1:0];
            end
            default: begin
                tmr_link.tick = 1'b0;
                tmr_link.limit = '0;
            end
        endcase
    end

    pus_timer u_timer (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .tmr(tmr_link)
    );

    // ------------------------------------------------------------------
    // Reset and sleep outputs
    // ------------------------------------------------------------------
    assign sleep_next = (state_d == PUS_ST_SLEEP);

    // Time-outs ignore the pin; the pin alone gates the final release
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_core_reset <= 1'b1;
        end else begin
            o_core_reset <= !i_master_clear_pin_n ||
                            !(state_d == PUS_ST_RUN || sleep_next);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_osc_stop <= 1'b0;
            o_hold_first_quarter_phase <= 1'b0;
        end else begin
            o_osc_stop <= sleep_next;
            o_hold_first_quarter_phase <= sleep_next;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_osc_out_port_a_bits_6 <= 1'b0;
            o_osc_out_drive_low <= 1'b0;
            o_feedback_inv_disable <= 1'b0;
        end else begin
            o_osc_out_port_a_bits_6 <= sleep_next && osc_mode == PUS_MODE_EXTERNAL_CLOCK_IO_MODE;
            o_osc_out_drive_low <= sleep_next && osc_mode == PUS_MODE_EC;
            o_feedback_inv_disable <= sleep_next &&
                (osc_mode == PUS_MODE_HS || osc_mode == PUS_MODE_HIGH_SPEED_PLL_MODE);
        end
    end

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------
    assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
    assign wb_wr = wb_req && i_wb_we && i_wb_sel[0];

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_wb_ack <= 1'b0;
        end else begin
            o_wb_ack <= wb_req;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            cfg_q <= PUS_CFG_RESET;
        end else if (wb_wr && i_wb_adr == PUS_ADDR_CONFIG) begin
            cfg_q <= i_wb_dat[4:0];
        end
    end

    // Cause flags: hardware set wins over write-one-to-clear
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            por_flag_q <= 1'b0;
            bor_flag_q <= 1'b0;
        end else begin
            if (state_q == PUS_ST_POR) begin
                por_flag_q <= 1'b1;
            end else if (wb_wr && i_wb_adr == PUS_ADDR_STATUS &&
                         i_wb_dat[PUS_ST_POR_FLAG_BIT]) begin
                por_flag_q <= 1'b0;
            end
            if (state_q == PUS_ST_BOR) begin
                bor_flag_q <= 1'b1;
            end else if (wb_wr && i_wb_adr == PUS_ADDR_STATUS &&
                         i_wb_dat[PUS_ST_BOR_FLAG_BIT]) begin
                bor_flag_q <= 1'b0;
            end
        end
    end

    always_comb begin
        status_word = '0;
        status_word[PUS_ST_STATE_LSB +: 3] = state_q;
        status_word[PUS_ST_POR_FLAG_BIT] = por_flag_q;
        status_word[PUS_ST_BOR_FLAG_BIT] = bor_flag_q;
        status_word[PUS_ST_RESET_BIT] = o_core_reset;
        status_word[PUS_ST_SLEEP_BIT] = (state_q == PUS_ST_SLEEP);
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_wb_dat <= '0;
        end else if (wb_req && !i_wb_we) begin
            case (i_wb_adr)
                PUS_ADDR_CONFIG: begin
                    o_wb_dat <= {27'h0000000, cfg_q};
                end
                PUS_ADDR_STATUS: begin
                    o_wb_dat <= status_word;
                end
                default: begin
                    o_wb_dat <= '0;
                end
            endcase
        end
    end

endmodule

//--- src/pus_timer.sv
// Stage timer: counts source-clock ticks up to a limit.
// Assumes ticks are one-cycle pulses synchronous to i_sys_clk.
`timescale 1ns/100ps
module pus_timer
    import pus_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    pus_tmr_if.tmr tmr
);
    logic [PUS_TMR_W-1:0] count_q;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || tmr.clr) begin
            count_q <= '0;
        end else if (tmr.tick && !tmr.done) begin
            count_q <= count_q + 1'b1;
        end
    end

    assign tmr.done = (count_q == tmr.limit);
endmodule
